// ---- logic/bst_pkg.sv ----
// Constants and types for the boundary-scan test port.
// Assumes a single system clock that samples the slow test clock as data.
//
// Functional notes
// - Follow standard boundary-scan architecture and behaviour.
// - Sample on test clock rise, drive output on fall.
// - Undriven mode select reads as logic high.
// - One register between serial in and out.
// - Serial in at MSB, out from LSB.
// - Serial output driven only in shift states.
// - Test reset leaves memory operation untouched.
// - Power-up resets controller, serial output floats.
// - Three-bit instruction register loaded serially.
// - Identify instruction loaded at reset state.
// - Capture-IR forces low instruction bits to 01.
// - One-bit bypass register cleared on capture.
// - Boundary register captures pins, shifts in Shift-DR.
// - External, sample and float-sample capture pin ring.
// - Chain includes cells for unconnected package positions.
// - Identify instruction captures fixed 32-bit value.
// - Identification value hardwired, shifted in Shift-DR.
// - Float-sample floats output bus until Update-IR.
// - Cell 108 gates bus; preset high.

package bst_pkg;

    // ------------------------------------------------------------
    // Register widths and chain geometry
    // ------------------------------------------------------------
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_LEN = 109;
    localparam int BSR_OE_CELL = 108;

    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam logic [2:0] INSTR_EXTEST = 3'h0;
    localparam logic [2:0] INSTR_IDCODE = 3'h1;
    localparam logic [2:0] INSTR_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INSTR_SAMPLE = 3'h4;
    localparam logic [2:0] INSTR_BYPASS = 3'h7;

    // ------------------------------------------------------------
    // Capture values, reset values and counts
    // ------------------------------------------------------------
    localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
    localparam logic IR_CAPTURE_MSB = 1'h0;
    localparam logic BYPASS_CAPTURE = 1'h0;
    localparam logic OE_CELL_PRESET = 1'h1;
    localparam logic OTHER_CELL_PRESET = 1'h0;
    localparam int TMS_RESET_EDGES = 5;
    localparam logic [2:0] TMS_CNT_MAX = 3'h5;
    // Synchroniser reset pattern {tdi, tms, tck}: pulled-up pins read high
    localparam logic [2:0] SYNC_RST_VAL = 3'h6;

    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE,
        ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
        ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
        ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } bst_state_type;

endpackage : bst_pkg

// ---- logic/bst_sync.sv ----
// Two-flop synchroniser for a group of slow asynchronous pins.
// Assumes each bit is independent; reset value is a constant pattern.
`timescale 1ns/1ps

module bst_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // ------------------------------------------------------------
    // Two flops; the first is read only by the second
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_q <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : bst_sync

// ---- logic/bst_tap.sv ----
// Boundary-scan test port: controller, instruction, bypass, ID and
// boundary registers, serial output driver.
// Assumes tck_in is far slower than clk_in (at least 4 clocks per half
// period) and the pad ring pull-ups hold tms_in and tdi_in high.
`timescale 1ns/1ps

module bst_tap
    import bst_pkg::*;
#(
    parameter logic [ID_W-1:0] ID_CODE = 32'h0A5A_5001 // Arbitrary value
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic [BSR_LEN-1:0] pin_ring_in,
    output logic tdo_out,
    output logic tdo_oe_n_out,
    output logic [BSR_LEN-1:0] bsr_par_out,
    output logic extest_out,
    output logic q_drive_en_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0] sync_s;
    logic [BSR_LEN-1:0] ring_s;
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tck_prev_q;
    logic tck_rise;
    logic tck_fall;
    bst_state_type state_q;
    bst_state_type state_d;
    logic [IR_W-1:0] ir_shift_q;
    logic [IR_W-1:0] ir_q;
    logic bypass_q;
    logic [ID_W-1:0] id_shift_q;
    logic [BSR_LEN-1:0] bsr_shift_q;
    logic [BSR_LEN-1:0] bsr_upd_q;
    logic sel_bsr;
    logic sel_id;
    logic dr_lsb;
    logic in_shift;
    logic tdo_q;
    logic tdo_oe_n_q;
    logic extest_q;
    logic q_drive_en_q;
    logic [2:0] tms_hi_cnt_q;

    // ------------------------------------------------------------
    // Pin synchronisers and test clock edge detect
    // ------------------------------------------------------------
    bst_sync #(
        .W(3),
        .RST_VAL(SYNC_RST_VAL)
    ) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in({tdi_in, tms_in, tck_in}),
        .sync_out(sync_s)
    );

    // Pad ring levels come from the memory clock domain
    bst_sync #(
        .W(BSR_LEN)
    ) u_ring_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in(pin_ring_in),
        .sync_out(ring_s)
    );

    assign tck_s = sync_s[0];
    assign tms_s = sync_s[1];
    assign tdi_s = sync_s[2];

    // Previous test clock level for edge finding
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tck_prev_q <= 1'b0;
        end else begin
            tck_prev_q <= tck_s;
        end
    end

    assign tck_rise = tck_s & ~tck_prev_q;
    assign tck_fall = ~tck_s & tck_prev_q;

    // ------------------------------------------------------------
    // Controller state sequence
    // ------------------------------------------------------------
    // Next state from mode select, standard sixteen-state graph
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RESET: state_d = tms_s ? ST_RESET : ST_IDLE;
            ST_IDLE: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_d = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: state_d = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_d = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_d = tms_s ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_d = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: state_d = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_d = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: state_d = tms_s ? ST_SEL_DR : ST_IDLE;
            default: state_d = ST_RESET;
        endcase
    end

    // State advances on each test clock rise; power-up forces reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= ST_RESET;
        end else if (tck_rise) begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    // Shift stage: capture fixed pattern, shift MSB-in LSB-out
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ir_shift_q <= INSTR_IDCODE;
        end else if (tck_rise) begin
            if (state_q == ST_CAP_IR) begin
                ir_shift_q <= {IR_CAPTURE_MSB, IR_CAPTURE_PAT};
            end else if (state_q == ST_SHIFT_IR) begin
                ir_shift_q <= {tdi_s, ir_shift_q[IR_W-1:1]};
            end
        end
    end

    // Current instruction: identify after reset, new code at Update-IR
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ir_q <= INSTR_IDCODE;
        end else if (state_q == ST_RESET) begin
            ir_q <= INSTR_IDCODE;
        end else if (tck_rise && state_q == ST_UPD_IR) begin
            ir_q <= ir_shift_q;
        end
    end

    // ------------------------------------------------------------
    // Data register selection
    // ------------------------------------------------------------
    // Reserved codes fall through to bypass
    always_comb begin
        sel_bsr = 1'b0;
        sel_id = 1'b0;
        case (ir_q)
            INSTR_EXTEST, INSTR_SAMPLE, INSTR_SAMPLE_Z: sel_bsr = 1'b1;
            INSTR_IDCODE: sel_id = 1'b1;
            default: sel_bsr = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Bypass and identification registers
    // ------------------------------------------------------------
    // Bypass: cleared at capture, one-stage shift
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bypass_q <= BYPASS_CAPTURE;
        end else if (tck_rise && !sel_bsr && !sel_id) begin
            if (state_q == ST_CAP_DR) begin
                bypass_q <= BYPASS_CAPTURE;
            end else if (state_q == ST_SHIFT_DR) begin
                bypass_q <= tdi_s;
            end
        end
    end

    // Identification: hardwired value captured, then shifted out
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            id_shift_q <= ID_CODE;
        end else if (tck_rise && sel_id) begin
            if (state_q == ST_CAP_DR) begin
                id_shift_q <= ID_CODE;
            end else if (state_q == ST_SHIFT_DR) begin
                id_shift_q <= {tdi_s, id_shift_q[ID_W-1:1]};
            end
        end
    end

    // ------------------------------------------------------------
    // Boundary scan cells, one per package bump incl. unconnected
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < BSR_LEN; gi++) begin : g_cell
            // Serial feed: MSB takes the input pin, others the next cell
            logic ser_d;
            if (gi == BSR_LEN - 1) begin : g_top
                assign ser_d = tdi_s;
            end else begin : g_mid
                assign ser_d = bsr_shift_q[gi+1];
            end

            // Capture stage: pin ring at Capture-DR, shift in Shift-DR
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    bsr_shift_q[gi] <= 1'b0;
                end else if (tck_rise && sel_bsr) begin
                    if (state_q == ST_CAP_DR) begin
                        bsr_shift_q[gi] <= ring_s[gi];
                    end else if (state_q == ST_SHIFT_DR) begin
                        bsr_shift_q[gi] <= ser_d;
                    end
                end
            end

            // Update stage: latched at Update-DR, preset at test reset
            always_ff @(posedge clk_in) begin
                if (rst_in || state_q == ST_RESET) begin
                    bsr_upd_q[gi] <= (gi == BSR_OE_CELL) ? OE_CELL_PRESET
                                                        : OTHER_CELL_PRESET;
                end else if (tck_rise && sel_bsr && state_q == ST_UPD_DR) begin
                    bsr_upd_q[gi] <= bsr_shift_q[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Serial output, changed on test clock fall only
    // ------------------------------------------------------------
    assign in_shift = (state_q == ST_SHIFT_DR) || (state_q == ST_SHIFT_IR);

    // LSB of the one selected register
    always_comb begin
        if (sel_bsr) begin
            dr_lsb = bsr_shift_q[0];
        end else if (sel_id) begin
            dr_lsb = id_shift_q[0];
        end else begin
            dr_lsb = bypass_q;
        end
    end

    // Driver data and enable; float outside the shift states
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tdo_q <= 1'b0;
            tdo_oe_n_q <= 1'b1;
        end else if (tck_fall) begin
            tdo_oe_n_q <= ~in_shift;
            if (state_q == ST_SHIFT_IR) begin
                tdo_q <= ir_shift_q[0];
            end else if (state_q == ST_SHIFT_DR) begin
                tdo_q <= dr_lsb;
            end
        end
    end

    // ------------------------------------------------------------
    // Output bus control toward the memory pad ring
    // ------------------------------------------------------------
    // Test reset keeps drivers enabled so memory traffic is unaffected
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            extest_q <= 1'b0;
            q_drive_en_q <= 1'b1;
        end else begin
            extest_q <= (ir_q == INSTR_EXTEST);
            if (ir_q == INSTR_SAMPLE_Z) begin
                q_drive_en_q <= 1'b0;
            end else if (ir_q == INSTR_EXTEST) begin
                q_drive_en_q <= bsr_upd_q[BSR_OE_CELL];
            end else begin
                q_drive_en_q <= 1'b1;
            end
        end
    end

    assign tdo_out = tdo_q;
    assign tdo_oe_n_out = tdo_oe_n_q;
    assign bsr_par_out = bsr_upd_q;
    assign extest_out = extest_q;
    assign q_drive_en_out = q_drive_en_q;

    // ------------------------------------------------------------
    // Checking helper: consecutive high mode-select rises
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tms_hi_cnt_q <= 3'h0;
        end else if (tck_rise) begin
            if (!tms_s) begin
                tms_hi_cnt_q <= 3'h0;
            end else if (tms_hi_cnt_q != TMS_CNT_MAX) begin
                tms_hi_cnt_q <= tms_hi_cnt_q + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_five_tms_reset: assert property (@(posedge clk_in) disable iff (rst_in)
        (tms_hi_cnt_q == TMS_CNT_MAX) |-> (state_q == ST_RESET))
        else $error("five high mode-select edges did not reach reset");

    a_reset_loads_id: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_q == ST_RESET) |=> (ir_q == INSTR_IDCODE))
        else $error("reset state did not load identify instruction");

    a_capture_ir_pattern: assert property (@(posedge clk_in) disable iff (rst_in)
        (tck_rise && state_q == ST_CAP_IR) |=> (ir_shift_q[1:0] == 2'h1))
        else $error("instruction capture pattern wrong");

    a_bypass_cleared: assert property (@(posedge clk_in) disable iff (rst_in)
        (tck_rise && state_q == ST_CAP_DR && ir_q == INSTR_BYPASS) |=> !bypass_q)
        else $error("bypass not cleared at capture");

    a_id_capture_value: assert property (@(posedge clk_in) disable iff (rst_in)
        (tck_rise && state_q == ST_CAP_DR && ir_q == INSTR_IDCODE)
        |=> (id_shift_q == ID_CODE))
        else $error("identification value not captured");

    a_id_shift_msb: assert property (@(posedge clk_in) disable iff (rst_in)
        (tck_rise && state_q == ST_SHIFT_DR && ir_q == INSTR_IDCODE)
        |=> (id_shift_q[ID_W-1] == $past(tdi_s))
            && (id_shift_q[ID_W-2:0] == $past(id_shift_q[ID_W-1:1])))
        else $error("identification shift direction wrong");

    a_tdo_fall_only: assert property (@(posedge clk_in) disable iff (rst_in)
        ($changed(tdo_q) || $changed(tdo_oe_n_q)) |-> $past(tck_fall))
        else $error("serial output changed away from a falling edge");

    a_tdo_float_idle: assert property (@(posedge clk_in) disable iff (rst_in)
        (tck_fall && !in_shift) |=> tdo_oe_n_q ##1 tdo_oe_n_q)
        else $error("serial output driven outside shift states");

    a_samplez_floats: assert property (@(posedge clk_in) disable iff (rst_in)
        (ir_q == INSTR_SAMPLE_Z) |=> !q_drive_en_q)
        else $error("output bus not floated by float-sample");

    a_extest_gate: assert property (@(posedge clk_in) disable iff (rst_in)
        (ir_q == INSTR_EXTEST) |=> (q_drive_en_q == $past(bsr_upd_q[BSR_OE_CELL])))
        else $error("gating cell does not control output bus");

endmodule : bst_tap

// ---- test/bst_scan_ctrl.sv ----
// Behavioural external scan controller: drives test clock, mode select, data.
// Assumes the caller enters each task just after a system clock edge.
`timescale 1ns/1ps

module bst_scan_ctrl (
    input wire logic tdo_in,
    input wire logic tdo_oe_n_in,
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out
);
    // ------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------
    // Clock stands low between frames; pulled-up lines rest high
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
    end

    // ------------------------------------------------------------
    // Clock periods
    // ------------------------------------------------------------
    // One 400 ns period; TDO is read at the rise, checked again before the fall
    task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v,
                        output logic oe_n_v, output logic stable_v);
        tms_out = tms_v;
        tdi_out = tdi_v;
        #200;
        tdo_v = tdo_in;
        oe_n_v = tdo_oe_n_in;
        tck_out = 1'b1;
        #198;
        stable_v = (tdo_in === tdo_v) && (tdo_oe_n_in === oe_n_v);
        #2;
        tck_out = 1'b0;
    endtask : step

    // Test-logic reset: mode select high for five rises
    task automatic tlr_reset();
        logic a, b, c;
        repeat (5) step(1'b1, 1'b1, a, b, c);
    endtask : tlr_reset
endmodule : bst_scan_ctrl

// ---- test/tb_top.sv ----
// Self-checking bench for the boundary-scan test port.
// Assumes the scan controller model drives the test pins at 400 ns period.
`timescale 1ns/1ps

module tb_top;
    import bst_pkg::*;
    localparam logic [ID_W-1:0] TB_ID = 32'h5C3A_96E1; // Arbitrary value
    localparam logic [BSR_LEN-1:0] PAT_A = {1'h1, {27{4'hA}}};
    localparam logic [BSR_LEN-1:0] PAT_B = {1'h0, {27{4'hC}}};
    localparam logic [BSR_LEN-1:0] PAT_C = {1'h1, {27{4'h6}}};
    localparam logic [BSR_LEN-1:0] PAT_P = {1'h0, {27{4'h3}}};
    localparam logic [BSR_LEN-1:0] PAT_Q = {1'h1, {27{4'h5}}};
    localparam logic [BSR_LEN-1:0] OE_ONLY = {1'h1, 108'h0};
    logic clk_in, rst_in, tck, tms, tdi, tdo_out, tdo_oe_n_out, extest_out, q_drive_en_out;
    logic [BSR_LEN-1:0] pin_ring_in, bsr_par_out;
    int err_total, checks;

    // ------------------------------------------------------------
    // Instances and clock
    // ------------------------------------------------------------
    bst_tap #(.ID_CODE(TB_ID)) u_bst_tap (.clk_in(clk_in), .rst_in(rst_in), .tck_in(tck),
        .tms_in(tms), .tdi_in(tdi), .pin_ring_in(pin_ring_in), .tdo_out(tdo_out),
        .tdo_oe_n_out(tdo_oe_n_out), .bsr_par_out(bsr_par_out), .extest_out(extest_out),
        .q_drive_en_out(q_drive_en_out));
    bst_scan_ctrl u_bst_scan_ctrl (.tdo_in(tdo_out), .tdo_oe_n_in(tdo_oe_n_out),
        .tck_out(tck), .tms_out(tms), .tdi_out(tdi));

    // 20 MHz system clock
    initial clk_in = 1'b0;
    always #25 clk_in = ~clk_in;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Compare and count
    task automatic chk(input string name, input logic [BSR_LEN-1:0] exp,
                       input logic [BSR_LEN-1:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One-bit results, widened on purpose
    task automatic chk_bit(input string name, input logic exp, input logic got);
        chk(name, BSR_LEN'(exp), BSR_LEN'(got));
    endtask : chk_bit

    // Full scan from Idle back to Idle; bit i of dout left TDO i-th
    task automatic scan(input bit ir, input int n, input logic [BSR_LEN-1:0] din,
                        output logic [BSR_LEN-1:0] dout);
        logic t, o, s, all_s, all_o;
        dout = '0;
        all_s = 1'b1;
        all_o = 1'b0;
        u_bst_scan_ctrl.step(1'b1, 1'b1, t, o, s);
        if (ir) u_bst_scan_ctrl.step(1'b1, 1'b1, t, o, s);
        u_bst_scan_ctrl.step(1'b0, 1'b1, t, o, s);
        u_bst_scan_ctrl.step(1'b0, 1'b1, t, o, s);
        for (int i = 0; i < n; i++) begin
            u_bst_scan_ctrl.step(i == n - 1, din[i], t, o, s);
            dout[i] = t;
            all_s = all_s & s;
            all_o = all_o | o;
        end
        u_bst_scan_ctrl.step(1'b1, 1'b1, t, o, s);
        u_bst_scan_ctrl.step(1'b0, 1'b1, t, o, s);
        chk_bit("tdo_stable_while_high", 1'b1, all_s);
        chk_bit("tdo_oe_n_in_shift", 1'b0, all_o);
        chk_bit("tdo_oe_n_idle", 1'b1, tdo_oe_n_out);
    endtask : scan

    // Instruction load, checking the captured pattern
    task automatic load_ir(input logic [IR_W-1:0] code);
        logic [BSR_LEN-1:0] d;
        scan(1'b1, IR_W, BSR_LEN'(code), d);
        chk("ir_capture", BSR_LEN'({IR_CAPTURE_MSB, IR_CAPTURE_PAT}), BSR_LEN'(d[2:0]));
    endtask : load_ir

    // Closing verdict
    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Outputs straight after power-up reset, then move to Idle
    task automatic t_reset_vals();
        logic a, b, c;
        chk_bit("oe_n_reset", 1'b1, tdo_oe_n_out);
        chk_bit("extest_reset", 1'b0, extest_out);
        chk_bit("q_en_reset", 1'b1, q_drive_en_out);
        chk("bsr_par_reset", OE_ONLY, bsr_par_out);
        u_bst_scan_ctrl.step(1'b0, 1'b1, a, b, c);
    endtask : t_reset_vals

    // Identification read, then the data shifted in follows it out
    task automatic t_idcode();
        logic [BSR_LEN-1:0] d;
        scan(1'b0, 36, PAT_A, d);
        chk("id_value", BSR_LEN'(TB_ID), BSR_LEN'(d[31:0]));
        chk("id_tail", BSR_LEN'(PAT_A[3:0]), BSR_LEN'(d[35:32]));
    endtask : t_idcode

    // Bypass and every reserved code: one-bit path, cleared at capture
    task automatic t_bypass();
        logic [IR_W-1:0] codes [4] = '{3'h3, 3'h5, 3'h6, INSTR_BYPASS};
        logic [BSR_LEN-1:0] d;
        foreach (codes[k]) begin
            load_ir(codes[k]);
            chk_bit("q_en_bypass", 1'b1, q_drive_en_out);
            chk_bit("extest_bypass", 1'b0, extest_out);
            scan(1'b0, 8, PAT_Q, d);
            chk_bit("bypass_capture", 1'b0, d[0]);
            chk("bypass_path", BSR_LEN'(PAT_Q[6:0]), BSR_LEN'(d[7:1]));
        end
    endtask : t_bypass

    // Sample, external and float-sample captures, preload and bus gating
    task automatic t_boundary();
        logic [BSR_LEN-1:0] d;
        pin_ring_in = PAT_A;
        load_ir(INSTR_SAMPLE);
        scan(1'b0, BSR_LEN, PAT_P, d);
        chk("sample_capture", PAT_A, d);
        chk("preload", PAT_P, bsr_par_out);
        chk_bit("q_en_sample", 1'b1, q_drive_en_out);
        pin_ring_in = PAT_B;
        load_ir(INSTR_EXTEST);
        chk_bit("extest_on", 1'b1, extest_out);
        chk_bit("q_en_cell_low", 1'b0, q_drive_en_out);
        scan(1'b0, BSR_LEN, PAT_Q, d);
        chk("extest_capture", PAT_B, d);
        chk_bit("q_en_cell_high", 1'b1, q_drive_en_out);
        pin_ring_in = PAT_C;
        load_ir(INSTR_SAMPLE_Z);
        chk_bit("q_en_float", 1'b0, q_drive_en_out);
        scan(1'b0, BSR_LEN, PAT_A, d);
        chk("float_capture", PAT_C, d);
        chk_bit("q_en_float_hold", 1'b0, q_drive_en_out);
    endtask : t_boundary

    // Mode-select reset from float-sample: defaults back, identify selected
    task automatic t_tms_reset();
        logic a, b, c;
        logic [BSR_LEN-1:0] d;
        u_bst_scan_ctrl.tlr_reset();
        chk_bit("q_en_tlr", 1'b1, q_drive_en_out);
        chk_bit("extest_tlr", 1'b0, extest_out);
        chk("bsr_par_tlr", OE_ONLY, bsr_par_out);
        chk_bit("oe_n_tlr", 1'b1, tdo_oe_n_out);
        u_bst_scan_ctrl.step(1'b0, 1'b1, a, b, c);
        scan(1'b0, ID_W, PAT_B, d);
        chk("id_after_tlr", BSR_LEN'(TB_ID), BSR_LEN'(d[31:0]));
    endtask : t_tms_reset

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    // Reset for 20 clocks, then each scenario in turn
    initial begin
        err_total = 0;
        checks = 0;
        rst_in = 1'b1;
        pin_ring_in = '0;
        repeat (20) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        t_reset_vals();
        t_idcode();
        t_bypass();
        t_boundary();
        t_tms_reset();
        report_and_stop();
    end

    // Cuts a hang short
    initial begin
        #2000000;
        err_total++;
        $display("[ERR] run_time expected done seen timeout");
        report_and_stop();
    end
endmodule : tb_top
